/* File: acc_pkg.sv */
// constants and types shared by the conversion-control block
package acc_pkg;
  // serial opcodes
  localparam logic [7:0] ACC_OP_RESET  = 8'h06;
  localparam logic [7:0] ACC_OP_START  = 8'h08;
  localparam logic [7:0] ACC_OP_STOP   = 8'h0A;
  localparam logic [2:0] ACC_TAG_REGISTER_WRITE_CMD  = 3'h2;
  localparam logic [2:0] ACC_TAG_RREG  = 3'h1;
  // bit counts within an opcode byte (zero based)
  localparam logic [2:0] ACC_BIT_SEVENTH = 3'h6;
  localparam logic [2:0] ACC_BIT_EIGHTH  = 3'h7;
  // register addresses and fields
  localparam logic [4:0] ACC_ADDR_CFG1 = 5'h01;
  localparam logic [4:0] ACC_ADDR_RESPIRATION_REGISTER = 5'h16;
  localparam logic [4:0] ACC_ADDR_CFG4 = 5'h17;
  localparam int         ACC_SINGLE_SHOT_BIT = 3;
  localparam int         ACC_RATE_LSB        = 0;
  localparam logic [7:0] ACC_CFG1_RST  = 8'h06;
  localparam logic [7:0] ACC_CFG4_RST  = 8'h00;
  localparam logic [7:0] ACC_RESPIRATION_REGISTER_RST  = 8'h00;
  // timing in master clock cycles
  localparam int ACC_RESTORE_CYC    = 18;
  localparam int ACC_FINISH_CYC     = 16;
  localparam int ACC_RST_MIN_CYC    = 2;
  localparam int ACC_WAKE_CYC       = 1024;
  localparam int ACC_RESULT_READY_N_LEAD_CYC  = 4;
  localparam int ACC_PERIOD_BASE    = 256;
  localparam int ACC_SETTLE_0 = 1160;
  localparam int ACC_SETTLE_1 = 2312;
  localparam int ACC_SETTLE_2 = 4616;
  localparam int ACC_SETTLE_3 = 9224;
  localparam int ACC_SETTLE_4 = 18440;
  localparam int ACC_SETTLE_5 = 36872;
  localparam int ACC_SETTLE_6 = 73736;
  localparam int ACC_CNT_W    = 17;
  // synchroniser lanes
  localparam int ACC_SY_PDN   = 0;
  localparam int ACC_SY_RST   = 1;
  localparam int ACC_SY_START = 2;
  localparam int ACC_SY_CS    = 3;
  localparam int ACC_SY_TSTA  = 4;
  localparam int ACC_SY_TSTO  = 5;
  localparam int ACC_SY_TRST  = 6;
  localparam int ACC_SY_TWR   = 7;
  localparam int ACC_SY_N     = 8;
  localparam logic [7:0] ACC_SY_INIT = 8'h0B;

  typedef enum logic [1:0] {
    ACC_BY_OP   = 2'b00,
    ACC_BY_CNT  = 2'b01,
    ACC_BY_DATA = 2'b10,
    ACC_BY_SKIP = 2'b11
  } acc_byte_t;

  typedef enum logic [2:0] {
    ACC_ST_PDN     = 3'b000,
    ACC_ST_WAKE    = 3'b001,
    ACC_ST_RESTORE = 3'b010,
    ACC_ST_IDLE    = 3'b011,
    ACC_ST_CONV    = 3'b100,
    ACC_ST_DONE    = 3'b101
  } acc_state_t;

  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] data;
  } acc_wr_t;
endpackage

/* File: acc_spi_rx.sv */
// serial opcode receiver on the serial clock domain
`timescale 1ns/1ps
module acc_spi_rx import acc_pkg::*; (
  input  wire logic sclk_i,
  input  wire logic cs_n_i,
  input  wire logic resetn_i,
  input  wire logic din_i,
  output logic      start_tgl_o,
  output logic      stop_tgl_o,
  output logic      reset_tgl_o,
  output logic      wr_tgl_o,
  output acc_wr_t   wr_o
);
  logic [2:0] bit_r, bit_nxt;
  acc_byte_t  byte_r, byte_nxt;
  logic [6:0] sh_r, sh_nxt;
  logic [4:0] addr_r, addr_nxt;
  logic [4:0] left_r, left_nxt;
  logic       wmode_r, wmode_nxt;
  logic       sta_r, sta_nxt, sto_r, sto_nxt, rst_r, rst_nxt, wt_r, wt_nxt;
  acc_wr_t    wr_r, wr_nxt;
  logic [7:0] full;

  always_comb begin
    full      = {sh_r, din_i};
    sh_nxt    = full[6:0];
    bit_nxt   = bit_r + 3'h1;
    byte_nxt  = byte_r;
    addr_nxt  = addr_r;
    left_nxt  = left_r;
    wmode_nxt = wmode_r;
    sta_nxt   = sta_r;
    sto_nxt   = sto_r;
    rst_nxt   = rst_r;
    wt_nxt    = wt_r;
    wr_nxt    = wr_r;
    if (!cs_n_i && bit_r == ACC_BIT_SEVENTH && byte_r == ACC_BY_OP) begin
      if (full[6:0] == ACC_OP_START[7:1]) sta_nxt = ~sta_r; // R14
      if (full[6:0] == ACC_OP_STOP[7:1]) sto_nxt = ~sto_r; // R14
    end
    if (!cs_n_i && bit_r == ACC_BIT_EIGHTH) begin
      case (byte_r)
        ACC_BY_OP: begin
          if (full == ACC_OP_RESET) rst_nxt = ~rst_r; // R4
          if (full[7:5] == ACC_TAG_REGISTER_WRITE_CMD || full[7:5] == ACC_TAG_RREG) begin
            byte_nxt  = ACC_BY_CNT;
            addr_nxt  = full[4:0];
            wmode_nxt = (full[7:5] == ACC_TAG_REGISTER_WRITE_CMD);
          end
        end
        ACC_BY_CNT: begin
          left_nxt = full[4:0];
          byte_nxt = wmode_r ? ACC_BY_DATA : ACC_BY_SKIP;
        end
        ACC_BY_DATA: begin
          wr_nxt   = '{addr: addr_r, data: full};
          wt_nxt   = ~wt_r;
          addr_nxt = addr_r + 5'h01;
          left_nxt = left_r - 5'h01;
          if (left_r == 5'h00) byte_nxt = ACC_BY_OP;
        end
        default: byte_nxt = ACC_BY_SKIP;
      endcase
    end
  end

  // chip select high restarts framing; a cut-short command cannot linger
  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      bit_r   <= 3'h0;
      byte_r  <= ACC_BY_OP;
      sh_r    <= 7'h00;
      addr_r  <= 5'h00;
      left_r  <= 5'h00;
      wmode_r <= 1'b0;
    end else begin
      bit_r   <= bit_nxt;
      byte_r  <= byte_nxt;
      sh_r    <= sh_nxt;
      addr_r  <= addr_nxt;
      left_r  <= left_nxt;
      wmode_r <= wmode_nxt;
    end
  end

  // toggles survive chip select so no event is lost at the crossing
  always_ff @(negedge sclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sta_r <= 1'b0;
      sto_r <= 1'b0;
      rst_r <= 1'b0;
      wt_r  <= 1'b0;
      wr_r  <= '0;
    end else begin
      sta_r <= sta_nxt;
      sto_r <= sto_nxt;
      rst_r <= rst_nxt;
      wt_r  <= wt_nxt;
      wr_r  <= wr_nxt;
    end
  end

  assign start_tgl_o = sta_r;
  assign stop_tgl_o  = sto_r;
  assign reset_tgl_o = rst_r;
  assign wr_tgl_o    = wt_r;
  assign wr_o        = wr_r;

  property p_start_op;
    @(negedge sclk_i) disable iff (cs_n_i || !resetn_i)
    (bit_r == ACC_BIT_SEVENTH && byte_r == ACC_BY_OP && full[6:0] == ACC_OP_START[7:1])
      |=> (sta_r != $past(sta_r));
  endproperty
  a_start_op: assert property (p_start_op) else $error("start opcode not taken"); // R14

  property p_reset_op;
    @(negedge sclk_i) disable iff (cs_n_i || !resetn_i)
    (bit_r == ACC_BIT_EIGHTH && byte_r == ACC_BY_OP && full == ACC_OP_RESET)
      |-> (rst_nxt != rst_r);
  endproperty
  a_reset_op: assert property (p_reset_op) else $error("reset opcode not taken"); // R4
endmodule

/* File: acc_conv_ctrl.sv */
// conversion control: power-down, reset, start/stop, data-ready, bus sharing
// Notes on behaviour
// R1: power-down pin low shuts circuitry; release starts a wake-up interval.
// R2: host should stop its external clock during power-down.
// R3: reset by reset pin held low long enough, or by reset opcode.
// R4: reset opcode acts on the eighth falling serial clock edge.
// R5: reset spends 18 cycles restoring defaults, then begins conversion cycle.
// R6: writing a new first-config or respiration value resets the filter.
// R7: no conversions and no data-ready until start pin or start opcode.
// R8: host keeps start pin low when using start and stop opcodes.
// R9: bit 3 of fourth config register set selects single-shot mode.
// R10: start drives data-ready high; its next fall marks the first result.
// R11: first-result delay per rate code: 1160 up to 73736 clock periods.
// R12: free-running filter settles in 3 periods; fourth data-ready is settled.
// R13: continuous conversions repeat until stop; current conversion finishes.
// R14: start and stop opcodes act on the seventh falling serial edge.
// R15: host stops 16 cycles before data-ready to halt further conversions.
// R16: after stop the current conversion completes, taking at least 16 cycles.
// R17: host pulses start or sends stop then start when changing mode.
// R18: single-shot converts once; data-ready then stays low, no more conversions.
// R19: host repeats start pin pulse or start opcode for another single shot.
// R20: each single-shot start resets the filter, quartering the output rate.
// R21: chip select high puts the shared data output in high impedance.
// R22: clock source pin high plus clock-out enable drives the shared clock.
// R23: data-ready falls when a result is ready, regardless of chip select.
`timescale 1ns/1ps
module acc_conv_ctrl import acc_pkg::*; #(
  parameter int unsigned SETTLE_CYC [0:6] = '{ACC_SETTLE_0, ACC_SETTLE_1, ACC_SETTLE_2,
                                             ACC_SETTLE_3, ACC_SETTLE_4, ACC_SETTLE_5,
                                             ACC_SETTLE_6},
  parameter int unsigned PERIOD_BASE      = ACC_PERIOD_BASE,
  parameter int unsigned WAKE_CYC         = ACC_WAKE_CYC
) (
  input  wire logic clk_i,
  input  wire logic resetn_i,
  input  wire logic sclk_i,
  input  wire logic cs_n_i,
  input  wire logic din_i,
  input  wire logic power_down_n_pin_i,
  input  wire logic reset_n_pin_i,
  input  wire logic start_pin_i,
  input  wire logic clock_source_pin_i,
  input  wire logic clk_out_en_i,
  output logic      result_ready_n_o,
  output logic      dout_o,
  output logic      dout_oe_o,
  output logic      analog_on_o,
  output logic      filter_reset_o,
  output logic      converting_o,
  output logic      single_shot_o,
  output logic      clk_out_o,
  output logic      clk_out_oe_o
);
  localparam logic [ACC_CNT_W-1:0] RESTORE_N = ACC_CNT_W'(ACC_RESTORE_CYC);
  localparam logic [ACC_CNT_W-1:0] FINISH_N  = ACC_CNT_W'(ACC_FINISH_CYC);
  localparam logic [ACC_CNT_W-1:0] LEAD_N    = ACC_CNT_W'(ACC_RESULT_READY_N_LEAD_CYC);
  localparam logic [ACC_CNT_W-1:0] WAKE_N    = ACC_CNT_W'(WAKE_CYC);
  localparam logic [ACC_CNT_W-1:0] ONE_N     = ACC_CNT_W'(1);
  localparam logic [2:0]           RST_MIN_N = 3'(ACC_RST_MIN_CYC);

  logic    lk_sta, lk_sto, lk_rst, lk_wt;
  acc_wr_t lk_wr;

  acc_spi_rx u_rx (
    .sclk_i      (sclk_i),
    .cs_n_i      (cs_n_i),
    .resetn_i    (resetn_i),
    .din_i       (din_i),
    .start_tgl_o (lk_sta),
    .stop_tgl_o  (lk_sto),
    .reset_tgl_o (lk_rst),
    .wr_tgl_o    (lk_wt),
    .wr_o        (lk_wr)
  );

  // three-stage synchronisers; a change counts when stages two and three agree
  logic [ACC_SY_N-1:0] sy_in, s1_r, s2_r, s3_r, filt_r, filt_nxt, prev_r;
  assign sy_in = {lk_wt, lk_rst, lk_sto, lk_sta, cs_n_i, start_pin_i, reset_n_pin_i,
                  power_down_n_pin_i};

  genvar g;
  generate
    for (g = 0; g < ACC_SY_N; g++) begin : g_sync
      assign filt_nxt[g] = (s2_r[g] == s3_r[g]) ? s2_r[g] : filt_r[g];
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          s1_r[g]   <= ACC_SY_INIT[g];
          s2_r[g]   <= ACC_SY_INIT[g];
          s3_r[g]   <= ACC_SY_INIT[g];
          filt_r[g] <= ACC_SY_INIT[g];
          prev_r[g] <= ACC_SY_INIT[g];
        end else begin
          s1_r[g]   <= sy_in[g];
          s2_r[g]   <= s1_r[g];
          s3_r[g]   <= s2_r[g];
          filt_r[g] <= filt_nxt[g];
          prev_r[g] <= filt_r[g];
        end
      end
    end
  endgenerate

  logic pdn_lvl, start_lvl, pin_rise, pin_fall;
  logic op_start, op_stop, op_reset, wr_ev, start_ev, stop_ev;
  assign pdn_lvl   = filt_r[ACC_SY_PDN];
  assign start_lvl = filt_r[ACC_SY_START];
  assign pin_rise  = start_lvl & ~prev_r[ACC_SY_START];
  assign pin_fall  = ~start_lvl & prev_r[ACC_SY_START];
  assign op_start  = filt_r[ACC_SY_TSTA] ^ prev_r[ACC_SY_TSTA];
  assign op_stop   = filt_r[ACC_SY_TSTO] ^ prev_r[ACC_SY_TSTO];
  assign op_reset  = filt_r[ACC_SY_TRST] ^ prev_r[ACC_SY_TRST];
  // payload has been still for many serial clocks when its toggle arrives here
  assign wr_ev     = filt_r[ACC_SY_TWR] ^ prev_r[ACC_SY_TWR];
  assign start_ev  = pin_rise | op_start;
  assign stop_ev   = pin_fall | op_stop;

  acc_state_t           state_r, state_nxt;
  logic [ACC_CNT_W-1:0] cnt_r, cnt_nxt;
  logic [2:0]           rlow_r, rlow_nxt;
  logic [7:0]           cfg1_r, cfg1_nxt, cfg4_r, cfg4_nxt, respiration_register_r, respiration_register_nxt;
  logic                 run_r, run_nxt, more_r, more_nxt, rdy_n_r, rdy_n_nxt;
  logic                 frst_r, frst_nxt, oe_r, oe_nxt, on_r, on_nxt;
  logic                 ck_r, ck_nxt, ckoe_r, ckoe_nxt, conv_r, conv_nxt;
  logic                 rst_hold, single, cfg_hit;
  logic [2:0]           rate;

  function automatic logic [ACC_CNT_W-1:0] settle_of(input logic [2:0] r);
    settle_of = ACC_CNT_W'(SETTLE_CYC[(r == 3'h7) ? 3'h6 : r]); // R11
  endfunction
  function automatic logic [ACC_CNT_W-1:0] period_of(input logic [2:0] r);
    period_of = ACC_CNT_W'(PERIOD_BASE << ((r == 3'h7) ? 3'h6 : r));
  endfunction
  assign rate     = cfg1_r[ACC_RATE_LSB +: 3];
  assign single   = cfg4_r[ACC_SINGLE_SHOT_BIT]; // R9
  assign rst_hold = (rlow_r >= RST_MIN_N);
  // a filter restart only when the stored value really changes
  assign cfg_hit  = wr_ev && ((lk_wr.addr == ACC_ADDR_CFG1 && lk_wr.data != cfg1_r) ||
                              (lk_wr.addr == ACC_ADDR_RESPIRATION_REGISTER && lk_wr.data != respiration_register_r)); // R6

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    cfg1_nxt  = cfg1_r;
    cfg4_nxt  = cfg4_r;
    respiration_register_nxt  = respiration_register_r;
    run_nxt   = run_r;
    more_nxt  = more_r;
    rdy_n_nxt = rdy_n_r;
    frst_nxt  = 1'b0;
    rlow_nxt  = filt_r[ACC_SY_RST] ? 3'h0 : (rst_hold ? rlow_r : rlow_r + 3'h1);
    if (!pdn_lvl) begin
      state_nxt = ACC_ST_PDN; // R1
      run_nxt   = 1'b0;
      more_nxt  = 1'b0;
      rdy_n_nxt = 1'b1;
    end else if (rst_hold || op_reset) begin
      state_nxt = ACC_ST_RESTORE; // R3
      cnt_nxt   = RESTORE_N;
      cfg1_nxt  = ACC_CFG1_RST;
      cfg4_nxt  = ACC_CFG4_RST;
      respiration_register_nxt  = ACC_RESPIRATION_REGISTER_RST;
      run_nxt   = 1'b0;
      more_nxt  = 1'b0;
      rdy_n_nxt = 1'b1;
    end else begin
      case (state_r)
        ACC_ST_PDN: begin
          state_nxt = ACC_ST_WAKE; // R1
          cnt_nxt   = WAKE_N;
        end
        ACC_ST_WAKE: begin
          cnt_nxt = cnt_r - ONE_N;
          if (cnt_r <= ONE_N) begin
            state_nxt = ACC_ST_RESTORE;
            cnt_nxt   = RESTORE_N;
          end
        end
        ACC_ST_RESTORE: begin
          cnt_nxt = cnt_r - ONE_N;
          if (cnt_r == ONE_N) begin
            // a start pin already high begins converting right away
            state_nxt = start_lvl ? ACC_ST_CONV : ACC_ST_IDLE; // R5
            run_nxt   = start_lvl;
            cnt_nxt   = settle_of(rate);
            frst_nxt  = 1'b1;
          end
        end
        default: begin
          if (wr_ev) begin
            if (lk_wr.addr == ACC_ADDR_CFG1) cfg1_nxt = lk_wr.data;
            if (lk_wr.addr == ACC_ADDR_CFG4) cfg4_nxt = lk_wr.data;
            if (lk_wr.addr == ACC_ADDR_RESPIRATION_REGISTER) respiration_register_nxt = lk_wr.data;
          end
          if (state_r == ACC_ST_CONV) begin
            cnt_nxt = cnt_r - ONE_N;
            if (cnt_r == LEAD_N) rdy_n_nxt = 1'b1;
            if (cnt_r == ONE_N) begin
              rdy_n_nxt = 1'b0; // R23
              if (single) begin
                state_nxt = ACC_ST_DONE; // R18
              end else if (run_r || more_r) begin
                // no filter restart between results, so a step settles in 3 periods
                cnt_nxt  = period_of(rate); // R12 R13
                more_nxt = 1'b0;
              end else begin
                state_nxt = ACC_ST_IDLE;
              end
            end
          end
          if (cfg_hit) begin
            frst_nxt = 1'b1; // R6
            if (state_r == ACC_ST_CONV) begin
              cnt_nxt   = settle_of(cfg1_nxt[ACC_RATE_LSB +: 3]);
              rdy_n_nxt = 1'b1;
            end
          end
          if (stop_ev) begin
            run_nxt = 1'b0; // R13
            // too close to the result: the next one counts as current too
            if (state_r == ACC_ST_CONV && !single && cnt_r <= FINISH_N) more_nxt = 1'b1; // R16
          end
          if (start_ev) begin
            state_nxt = ACC_ST_CONV; // R7
            run_nxt   = 1'b1;
            more_nxt  = 1'b0;
            rdy_n_nxt = 1'b1; // R10
            cnt_nxt   = settle_of(cfg1_nxt[ACC_RATE_LSB +: 3]); // R11
            frst_nxt  = 1'b1; // R20
          end
        end
      endcase
    end
    on_nxt   = (state_nxt != ACC_ST_PDN); // R1
    oe_nxt   = ~filt_r[ACC_SY_CS] & on_nxt; // R21
    ckoe_nxt = clock_source_pin_i & clk_out_en_i & on_nxt; // R22
    ck_nxt   = ckoe_nxt ? ~ck_r : 1'b0; // R22
    conv_nxt = (state_nxt == ACC_ST_CONV);
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= ACC_ST_RESTORE;
      cnt_r   <= RESTORE_N;
      rlow_r  <= 3'h0;
      cfg1_r  <= ACC_CFG1_RST;
      cfg4_r  <= ACC_CFG4_RST;
      respiration_register_r  <= ACC_RESPIRATION_REGISTER_RST;
      run_r   <= 1'b0;
      more_r  <= 1'b0;
      rdy_n_r <= 1'b1;
      frst_r  <= 1'b0;
      on_r    <= 1'b0;
      oe_r    <= 1'b0;
      ck_r    <= 1'b0;
      ckoe_r  <= 1'b0;
      conv_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      rlow_r  <= rlow_nxt;
      cfg1_r  <= cfg1_nxt;
      cfg4_r  <= cfg4_nxt;
      respiration_register_r  <= respiration_register_nxt;
      run_r   <= run_nxt;
      more_r  <= more_nxt;
      rdy_n_r <= rdy_n_nxt;
      frst_r  <= frst_nxt;
      on_r    <= on_nxt;
      oe_r    <= oe_nxt;
      ck_r    <= ck_nxt;
      ckoe_r  <= ckoe_nxt;
      conv_r  <= conv_nxt;
    end
  end

  assign result_ready_n_o = rdy_n_r;
  assign dout_o           = rdy_n_r;
  assign dout_oe_o        = oe_r;
  assign analog_on_o      = on_r;
  assign filter_reset_o   = frst_r;
  assign converting_o     = conv_r;
  assign single_shot_o    = single;
  assign clk_out_o        = ck_r;
  assign clk_out_oe_o     = ckoe_r;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  property p_pdn;
    !pdn_lvl |=> (state_r == ACC_ST_PDN) && !on_r && !oe_r;
  endproperty
  a_pdn: assert property (p_pdn) else $error("power-down not entered"); // R1
  property p_reset_op;
    (pdn_lvl && op_reset) |=> (state_r == ACC_ST_RESTORE) && (cnt_r == RESTORE_N) && rdy_n_r &&
                              (cfg1_r == ACC_CFG1_RST) && (cfg4_r == ACC_CFG4_RST);
  endproperty
  a_reset_op: assert property (p_reset_op) else $error("reset opcode ignored"); // R3
  property p_restore_len;
    (state_r == ACC_ST_RESTORE && pdn_lvl && !rst_hold && !op_reset)
      |=> (state_r == ACC_ST_RESTORE) ? (cnt_r == $past(cnt_r) - ONE_N) : ($past(cnt_r) == ONE_N);
  endproperty
  a_restore_len: assert property (p_restore_len) else $error("restore not 18 cycles"); // R5
  property p_idle_quiet;
    (state_r == ACC_ST_IDLE && pdn_lvl && !rst_hold && !op_reset && !start_ev)
      |=> $stable(rdy_n_r) && state_r != ACC_ST_CONV;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("conversion without start"); // R7
  property p_start;
    (start_ev && pdn_lvl && !rst_hold && !op_reset &&
     (state_r == ACC_ST_IDLE || state_r == ACC_ST_DONE))
      |=> rdy_n_r && converting_o && frst_r && cnt_r == settle_of(rate);
  endproperty
  a_start: assert property (p_start) else $error("start did not raise data-ready"); // R10 R11
  property p_cfg_filter;
    (cfg_hit && pdn_lvl && !rst_hold && !op_reset && state_r == ACC_ST_IDLE) |=> frst_r;
  endproperty
  a_cfg_filter: assert property (p_cfg_filter) else $error("filter not reset on write"); // R6
  property p_single;
    (state_r == ACC_ST_CONV && cnt_r == ONE_N && single && pdn_lvl && !rst_hold &&
     !op_reset && !start_ev && !cfg_hit)
      |=> !rdy_n_r && state_r == ACC_ST_DONE;
  endproperty
  a_single: assert property (p_single) else $error("single shot not stopped"); // R18
  property p_done_low;
    (state_r == ACC_ST_DONE && pdn_lvl && !rst_hold && !op_reset && !start_ev) |=> !rdy_n_r;
  endproperty
  a_done_low: assert property (p_done_low) else $error("data-ready rose after single"); // R18
  property p_stop_far;
    (stop_ev && !start_ev && state_r == ACC_ST_CONV && cnt_r > FINISH_N && !more_r)
      |=> !run_r && !more_r;
  endproperty
  a_stop_far: assert property (p_stop_far) else $error("stop not honoured"); // R13 R16
  property p_cs_hiz;
    filt_r[ACC_SY_CS] |=> !dout_oe_o;
  endproperty
  a_cs_hiz: assert property (p_cs_hiz) else $error("output driven while deselected"); // R21
  property p_clk_share;
    (clock_source_pin_i && clk_out_en_i && pdn_lvl) ##1 (clock_source_pin_i && clk_out_en_i)
      |-> clk_out_oe_o;
  endproperty
  a_clk_share: assert property (p_clk_share) else $error("clock out not enabled"); // R22
endmodule

/* File: acc_host_model.sv */
// host model: serial opcode and register-write frames
`timescale 1ns/1ps
module acc_host_model import acc_pkg::*; (
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o  = 1'b0;
  end
  // msb first, taken on the falling edge; clock stands still outside frames
  task automatic put(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      #3 sclk_o = 1'b1;
      din_o = b[i];
      #3 sclk_o = 1'b0;
    end
  endtask
  // released line shows inverse; cs held over 8 master cycles after last bit
  task automatic fin();
    #3 din_o = ~din_o;
    #210 cs_n_o = 1'b1;
    #210;
  endtask
  task automatic op(input logic [7:0] b);
    cs_n_o = 1'b0;
    put(b);
    fin();
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    cs_n_o = 1'b0;
    put({ACC_TAG_REGISTER_WRITE_CMD, a});
    put(8'h00);
    put(d);
    fin();
  endtask
endmodule

/* File: test_acc_conv_ctrl.sv */
// self-checking bench for the conversion-control block
`timescale 1ns/1ps
module test_acc_conv_ctrl import acc_pkg::*; ;
  localparam int unsigned ST [0:6] = '{40, 48, 56, 64, 72, 80, 88};
  localparam int          PB       = 16;
  logic clk, resetn, sclk, cs_n, din, pdn_n, rst_n, start, csrc, cken, run, b;
  logic rdy_n, dout, dout_oe, aon, frst, conv, sshot, cko, cko_oe, conv_q, rdy_q;
  int   miscompares, n_checks, cyc, n_fr, t_conv, t_fall, f1, k;

  acc_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din));
  acc_conv_ctrl #(.SETTLE_CYC(ST), .PERIOD_BASE(PB), .WAKE_CYC(8)) uut (
    .clk_i(clk), .resetn_i(resetn), .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din),
    .power_down_n_pin_i(pdn_n), .reset_n_pin_i(rst_n), .start_pin_i(start),
    .clock_source_pin_i(csrc), .clk_out_en_i(cken), .result_ready_n_o(rdy_n),
    .dout_o(dout), .dout_oe_o(dout_oe), .analog_on_o(aon), .filter_reset_o(frst),
    .converting_o(conv), .single_shot_o(sshot), .clk_out_o(cko), .clk_out_oe_o(cko_oe));

  initial begin
    clk = 1'b0;
    forever begin
      #12.5;
      if (run) clk = ~clk;
    end
  end

  // sampled mid-cycle so the launching edge has settled
  always @(negedge clk) begin
    cyc++;
    if (frst === 1'b1) n_fr++;
    if (conv === 1'b1 && conv_q !== 1'b1) t_conv = cyc;
    if (rdy_n === 1'b0 && rdy_q !== 1'b0) t_fall = cyc;
    conv_q = conv;
    rdy_q = rdy_n;
  end

  task automatic chk(input logic got, input logic exp, input string m);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic rng(input int got, input int lo, input int hi, input string m);
    chk(got >= lo && got <= hi, 1'b1, m);
  endtask
  function automatic logic sig(input int w);
    return w == 0 ? rdy_n : (w == 1 ? conv : aon);
  endfunction
  task automatic wt(input int w, input logic lv);
    k = 0;
    while (sig(w) !== lv && k < 3000) begin
      @(negedge clk);
      k++;
    end
    chk(sig(w), lv, "wait expired");
    #1;
  endtask
  task automatic cyc_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic close_out();
    if (miscompares == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #750000;
    miscompares++;
    close_out();
  end

  initial begin
    run = 1'b1;
    resetn = 1'b0;
    start = 1'b0;
    pdn_n = 1'b1;
    rst_n = 1'b1;
    csrc = 1'b0;
    cken = 1'b0;
    cyc_n(8);
    resetn = 1'b1;
    cyc_n(30);
    chk(conv, 1'b0, "converting before start");
    chk(rdy_n, 1'b1, "ready before start");
    chk(dout_oe, 1'b0, "dout driven while deselected");
    start = 1'b1;
    wt(1, 1'b1);
    chk(rdy_n, 1'b1, "ready high on start");
    wt(0, 1'b0);
    rng(t_fall - t_conv, ST[6] - 1, ST[6] + 1, "first result delay");
    f1 = t_fall;
    wt(0, 1'b1);
    wt(0, 1'b0);
    rng(t_fall - f1, (PB << 6) - 1, (PB << 6) + 1, "result period");
    // lowered right after a result, far ahead of the next one
    cyc_n(1);
    start = 1'b0;
    f1 = t_fall;
    wt(0, 1'b1);
    wt(0, 1'b0);
    rng(t_fall - f1, (PB << 6) - 1, (PB << 6) + 1, "current finishes");
    cyc_n(1100);
    chk(rdy_n, 1'b0, "ready held after stop");
    chk(conv, 1'b0, "no more conversions");
    chk(dout, 1'b0, "data out not mirroring ready");
    for (int r = 0; r < 7; r++) begin
      f1 = n_fr;
      host.wr(ACC_ADDR_CFG1, 8'(r));
      chk(n_fr == f1 + 1, 1'b1, "filter restart on write");
      host.op(ACC_OP_START);
      wt(0, 1'b0);
      rng(t_fall - t_conv, ST[r] - 1, ST[r] + 1, "settle per rate");
      host.op(ACC_OP_STOP);
      wt(1, 1'b0);
    end
    host.wr(ACC_ADDR_CFG4, 8'h08);
    chk(sshot, 1'b1, "single-shot select");
    for (int i = 0; i < 2; i++) begin
      f1 = n_fr;
      host.op(ACC_OP_START);
      chk(n_fr == f1 + 1, 1'b1, "filter restart on start");
      wt(0, 1'b0);
      rng(t_fall - t_conv, ST[6] - 1, ST[6] + 1, "single result");
      cyc_n(2100);
      chk(rdy_n, 1'b0, "ready stays low");
      chk(conv, 1'b0, "one conversion only");
    end
    host.op(ACC_OP_RESET);
    cyc_n(30);
    chk(sshot, 1'b0, "defaults after reset opcode");
    host.wr(ACC_ADDR_CFG4, 8'h08);
    cyc_n(1);
    rst_n = 1'b0;
    cyc_n(4);
    rst_n = 1'b1;
    cyc_n(30);
    chk(sshot, 1'b0, "defaults after reset pin");
    pdn_n = 1'b0;
    wt(2, 1'b0);
    run = 1'b0;
    #500 run = 1'b1;
    cyc_n(1);
    pdn_n = 1'b1;
    wt(2, 1'b1);
    csrc = 1'b1;
    cken = 1'b1;
    cyc_n(4);
    chk(cko_oe, 1'b1, "clock out enabled");
    b = cko;
    cyc_n(1);
    chk(cko, ~b, "clock out toggles");
    cken = 1'b0;
    cyc_n(4);
    chk(cko_oe, 1'b0, "clock out released");
    close_out();
  end
endmodule
